// >>> logic/sdwd_pkg.sv
// Purpose: Shared constants and types of the two-wire DAC write decoder
// Assumes: 7-bit addressing, write-only target
// Notes: Codes and bit positions used by the decoder top
`default_nettype none
package sdwd_pkg;
  localparam logic [6:0] SYNC_ADDR = 7'h7E;
  localparam logic [3:0] BASE_UPPER = 4'h4;
  localparam logic [3:0] ALT_UPPER = 4'h3;
  localparam logic WRITE_BIT = 1'h0;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int CMD_REF_BIT = 2;
  localparam int CMD_PD_BIT = 1;
  localparam int CMD_SYNC_BIT = 0;
  localparam logic [2:0] CMD_RESET = 3'h0;
  localparam logic [9:0] CODE_RESET = 10'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] PIN_IDLE = 3'h7;
  localparam int INT_REF_FULL_SCALE_MV = 2500;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_DLO,
    ST_DHI,
    ST_SKIP
  } sdwd_state_t;

  typedef struct packed {
    logic [2:0] sclS;
    logic [2:0] sdaS;
    logic [1:0] bitS;
    logic [2:0][2:0] pinS;
    logic sclLvl;
    logic sdaLvl;
    logic [2:0] pinLvl;
    sdwd_state_t st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic ackPhase;
    logic ackOn;
    logic sdaOeN;
    logic sdaOut;
    logic [2:0] cmdIn;
    logic [2:0] cmdOut;
    logic [7:0] loTmp;
    logic [9:0] codeIn;
    logic [9:0] codeOut;
    logic cmdPend;
    logic updPend;
  } sdwd_regs_t;

  function automatic logic [6:0] sdwd_own_addr(input logic alt, input logic [2:0] pins);
    sdwd_own_addr = {(alt ? ALT_UPPER : BASE_UPPER), pins};
  endfunction
endpackage
`default_nettype wire

// >>> logic/sdwd_decoder.sv
// Purpose: Target-side receive logic of a 10-bit DAC on a two-wire bus
// Assumes: Host drives SCL; SDA open drain resolved outside
// Notes: SCL clocks one capture flop; all else runs on mclk
//
// What this block does
// - First data byte holds code bits seven..zero
// - Command-only transfer sets command, never the code
// - Interrupted data bytes dropped, command byte kept
// - Interrupted command byte dropped, old command kept
// - Also answer the shared sync-update address
// - Sync flag high updates only if sync bit set
// - Sync flag low always clears the whole part
// - Internal reference gives fixed full-scale output
// - Word write acked per byte, copied at STOP unless sync bit set
// - Command bits: reference, power-down, sync; reset zero
// - Sync mode updates on sync ack rising edge
// - Address: four fixed upper bits plus pins
`default_nettype none
module sdwd_decoder #(
  parameter bit ALT_VARIANT = 1'b0
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic addrSelectPinHi,
  input wire logic addrSelectPinMid,
  input wire logic addrSelectPinLo,
  output logic [9:0] dacCode,
  output logic internalReferenceSelect,
  output logic powerDownRequest,
  output logic syncUpdateSelect
);
  import sdwd_pkg::*;

  sdwd_regs_t r;
  sdwd_regs_t n;
  logic capBit_r;

  // SDA sampled at the real SCL rising edge, crossed as a level
  always_ff @(posedge scl) begin
    capBit_r <= sdaIn;
  end

  logic sclNew;
  logic sdaNew;
  logic riseEv;
  logic fallEv;
  logic startDet;
  logic stopDet;
  logic [6:0] ownAddr;
  logic [9:0] dataWord;
  logic addrHit;
  logic ackRise;

  assign sclNew = (r.sclS[2] == r.sclS[1]) ? r.sclS[2] : r.sclLvl;
  assign sdaNew = (r.sdaS[2] == r.sdaS[1]) ? r.sdaS[2] : r.sdaLvl;
  assign riseEv = sclNew && !r.sclLvl;
  assign fallEv = !sclNew && r.sclLvl;
  assign startDet = r.sclLvl && sclNew && r.sdaLvl && !sdaNew;
  assign stopDet = r.sclLvl && sclNew && !r.sdaLvl && sdaNew;
  assign ownAddr = sdwd_own_addr(ALT_VARIANT, r.pinLvl);
  assign dataWord = {r.shift[1:0], r.loTmp};
  assign addrHit = (r.shift[7:1] == ownAddr && r.shift[0] == WRITE_BIT) ||
                   (r.shift[7:1] == SYNC_ADDR);
  assign ackRise = riseEv && r.bitCnt == ACK_SLOT && r.ackPhase && r.ackOn;

  always_comb begin
    n = r;
    n.sclS = {r.sclS[1:0], scl};
    n.sdaS = {r.sdaS[1:0], sdaIn};
    n.bitS = {r.bitS[0], capBit_r};
    n.pinS = {r.pinS[1:0], {addrSelectPinHi, addrSelectPinMid, addrSelectPinLo}};
    n.sclLvl = sclNew;
    n.sdaLvl = sdaNew;
    if (r.pinS[2] == r.pinS[1]) begin
      n.pinLvl = r.pinS[2];
    end
    n.sdaOut = 1'h0;
    if (startDet || stopDet) begin
      // Pending command or data bytes never reach input registers
      n.st = startDet ? ST_ADDR : ST_IDLE;
      n.bitCnt = 4'h0;
      n.ackPhase = 1'h0;
      n.ackOn = 1'h0;
      n.sdaOeN = 1'h1;
      if (stopDet) begin
        if (!r.cmdIn[CMD_SYNC_BIT]) begin
          if (r.cmdPend || r.updPend) begin
            n.cmdOut = r.cmdIn;
          end
          if (r.updPend) begin
            n.codeOut = r.codeIn;
          end
        end
        n.cmdPend = 1'h0;
        n.updPend = 1'h0;
      end
    end else if (riseEv && !r.ackPhase && r.bitCnt < ACK_SLOT) begin
      n.shift = {r.shift[6:0], r.bitS[1]};
      n.bitCnt = r.bitCnt + 4'h1;
    end else if (ackRise) begin
      unique case (r.st)
        ST_ADDR: begin
          if (r.shift[7:1] == SYNC_ADDR) begin
            n.st = ST_SKIP;
            if (r.shift[0]) begin
              if (r.cmdIn[CMD_SYNC_BIT]) begin
                n.codeOut = r.codeIn;
                n.cmdOut = r.cmdIn;
                n.updPend = 1'h0;
                n.cmdPend = 1'h0;
              end
            end else begin
              n.cmdIn = CMD_RESET;
              n.cmdOut = CMD_RESET;
              n.codeIn = CODE_RESET;
              n.codeOut = CODE_RESET;
              n.loTmp = BYTE_RESET;
              n.updPend = 1'h0;
              n.cmdPend = 1'h0;
            end
          end else begin
            n.st = ST_CMD;
          end
        end
        ST_CMD: begin
          n.cmdIn = r.shift[2:0];
          n.cmdPend = 1'h1;
          n.st = ST_DLO;
        end
        ST_DLO: begin
          n.loTmp = r.shift;
          n.st = ST_DHI;
        end
        ST_DHI: begin
          n.codeIn = dataWord;
          n.updPend = 1'h1;
          n.st = ST_SKIP;
        end
        ST_IDLE, ST_SKIP: begin
          n.st = ST_SKIP;
        end
      endcase
    end else if (fallEv && r.bitCnt == ACK_SLOT) begin
      if (!r.ackPhase) begin
        n.ackPhase = 1'h1;
        unique case (r.st)
          ST_ADDR: n.ackOn = addrHit;
          ST_CMD, ST_DLO, ST_DHI: n.ackOn = 1'h1;
          ST_IDLE, ST_SKIP: n.ackOn = 1'h0;
        endcase
        n.sdaOeN = !n.ackOn;
      end else begin
        n.ackPhase = 1'h0;
        n.ackOn = 1'h0;
        n.sdaOeN = 1'h1;
        n.bitCnt = 4'h0;
        if (!r.ackOn) begin
          n.st = ST_SKIP;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r <= '{sclS: PIN_IDLE, sdaS: PIN_IDLE, bitS: 2'h0, pinS: '0,
             sclLvl: 1'h1, sdaLvl: 1'h1, pinLvl: 3'h0, st: ST_IDLE,
             bitCnt: 4'h0, shift: BYTE_RESET, ackPhase: 1'h0, ackOn: 1'h0,
             sdaOeN: 1'h1, sdaOut: 1'h0, cmdIn: CMD_RESET, cmdOut: CMD_RESET,
             loTmp: BYTE_RESET, codeIn: CODE_RESET, codeOut: CODE_RESET,
             cmdPend: 1'h0, updPend: 1'h0};
    end else begin
      r <= n;
    end
  end

  assign sdaOut = r.sdaOut;
  assign sdaOeN = r.sdaOeN;
  assign dacCode = r.codeOut;
  assign internalReferenceSelect = r.cmdOut[CMD_REF_BIT];
  assign powerDownRequest = r.cmdOut[CMD_PD_BIT];
  assign syncUpdateSelect = r.cmdIn[CMD_SYNC_BIT];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence syncAckRise;
    ackRise && r.st == ST_ADDR && r.shift[7:1] == SYNC_ADDR;
  endsequence
  sequence interruptEv;
    startDet || stopDet;
  endsequence

  a_cmd_discard: assert property (r.st == ST_CMD ##0 interruptEv |=> $stable(r.cmdIn))
    else $error("command changed by interrupted transfer");
  a_data_discard: assert property ((r.st == ST_DLO || r.st == ST_DHI) ##0 interruptEv
    |=> $stable(r.codeIn) && r.cmdIn == $past(r.cmdIn))
    else $error("data taken from interrupted word");
  a_word_commit: assert property (ackRise && r.st == ST_DHI |=> r.codeIn == $past(dataWord)
    && r.updPend) else $error("word not assembled");
  a_stop_update: assert property (stopDet && r.updPend && !r.cmdIn[CMD_SYNC_BIT]
    |=> dacCode == $past(r.codeIn)) else $error("STOP did not update code");
  a_stop_hold: assert property (stopDet && r.cmdIn[CMD_SYNC_BIT] |=> $stable(dacCode))
    else $error("STOP updated in sync mode");
  a_send_byte: assert property (stopDet && r.cmdPend && !r.updPend && !r.cmdIn[CMD_SYNC_BIT]
    |=> $stable(dacCode)
    && powerDownRequest == $past(r.cmdIn[CMD_PD_BIT]))
    else $error("command-only transfer wrong");
  a_sync_update: assert property (syncAckRise ##0 r.shift[0] ##0 r.cmdIn[CMD_SYNC_BIT]
    |=> dacCode == $past(r.codeIn)) else $error("sync update missed");
  a_sync_ignore: assert property (syncAckRise ##0 r.shift[0] ##0 !r.cmdIn[CMD_SYNC_BIT]
    |=> $stable(dacCode)) else $error("sync update without sync bit");
  a_sync_clear: assert property (syncAckRise ##0 !r.shift[0] |=> dacCode == CODE_RESET
    && r.cmdIn == CMD_RESET && !powerDownRequest) else $error("clear failed");
  a_addr_ack: assert property (fallEv && r.bitCnt == ACK_SLOT && !r.ackPhase &&
    r.st == ST_ADDR && r.shift == {ownAddr, WRITE_BIT} |=> (!sdaOeN) [*2])
    else $error("own address not acked");
  a_ack_release: assert property (fallEv && r.ackPhase && !startDet |=> sdaOeN &&
    r.bitCnt == 4'h0) else $error("ack not released");
endmodule
`default_nettype wire

// >>> sim/sdwd_host.sv
// Purpose: Behavioural SMBus host on SCL and SDA
// Assumes: SDA pulled up; wire level resolved in the bench
// Notes: SCL toggles at 160 ns only inside frames
`default_nettype none
module sdwd_host (
  output logic scl,
  output logic sdaDrv,
  input wire logic sdaWire
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  // Start or repeated start
  task automatic frame_start();
    #7.3 sdaDrv = 1'b1;
    #40 scl = 1'b1;
    #40 sdaDrv = 1'b0;
    #40 scl = 1'b0;
    #40;
  endtask
  task automatic frame_stop();
    sdaDrv = 1'b0;
    #40 scl = 1'b1;
    #40 sdaDrv = 1'b1;
    #80;
  endtask
  // Bits MSB first, full byte gets an ack clock
  task automatic send_bits(input logic [7:0] val, input int n, output logic ack);
    ack = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdaDrv = val[7 - i];
      #40 scl = 1'b1;
      #80 scl = 1'b0;
      #40;
    end
    if (n == 8) begin
      sdaDrv = 1'b1;
      #40 scl = 1'b1;
      #40 ack = (sdaWire === 1'b0);
      #40 scl = 1'b0;
      #40;
    end
  endtask
endmodule
`default_nettype wire

// >>> sim/sdwd_decoder_test.sv
// Purpose: Self-checking bench of the two-wire DAC write decoder
// Assumes: Host model drives SCL and SDA
// Notes: Output changes matched against queued notes
`default_nettype none
module sdwd_decoder_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sdwd_pkg::*;
  logic mclk, sysRst, scl, sdaDrv, sdaOut, sdaOeN, refSel, pdReq, syncSel, a;
  logic [2:0] pins;
  logic [9:0] dacCode;
  logic [11:0] expQ[$];
  logic [11:0] curOut, prevOut;
  int errCount, nCompared;
  wire logic sdaWire;
  assign sdaWire = sdaDrv & (sdaOeN | sdaOut);
  sdwd_decoder sdwd_decoder_inst (.mclk(mclk), .sys_rst(sysRst), .scl(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .addrSelectPinHi(pins[2]), .addrSelectPinMid(pins[1]),
    .addrSelectPinLo(pins[0]), .dacCode(dacCode), .internalReferenceSelect(refSel),
    .powerDownRequest(pdReq), .syncUpdateSelect(syncSel));
  sdwd_host sdwd_host_inst (.scl(scl), .sdaDrv(sdaDrv), .sdaWire(sdaWire));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic note(input logic [9:0] code, input logic [7:0] cmd);
    if ({code, cmd[2:1]} !== curOut) expQ.push_back({code, cmd[2:1]});
    curOut = {code, cmd[2:1]};
  endtask
  task automatic xfer(input logic [0:3][7:0] b, input int nb, input logic [3:0] ea,
    input string what);
    logic [3:0] acks;
    acks = 4'h0;
    sdwd_host_inst.frame_start();
    for (int i = 0; i < nb; i++) begin
      sdwd_host_inst.send_bits(b[i], 8, a);
      acks[i] = a;
    end
    sdwd_host_inst.frame_stop();
    repeat (20) @(negedge mclk);
    chk({8'h00, acks}, {8'h00, ea}, what);
    $display("test %s done", what);
  endtask
  always @(negedge mclk) begin
    if (!sysRst && {dacCode, refSel, pdReq} !== prevOut) begin
      if (expQ.size() == 0) chk({dacCode, refSel, pdReq}, prevOut, "stray change");
      else chk({dacCode, refSel, pdReq}, expQ.pop_front(), "output value");
    end
    prevOut <= {dacCode, refSel, pdReq};
  end
  initial begin
    #400000;
    errCount++;
    $display("BAD %0t watchdog", $time);
    tally_and_finish();
  end
  initial begin
    logic [9:0] code;
    logic [7:0] cmd;
    logic [6:0] own;
    sysRst = 1'b1;
    pins = 3'h0;
    curOut = 12'h000;
    errCount = 0;
    nCompared = 0;
    void'($urandom(56));
    repeat (20) @(negedge mclk);
    sysRst = 1'b0;
    repeat (10) @(negedge mclk);
    chk({dacCode, refSel, pdReq}, 12'h000, "reset outputs");
    chk({10'h000, syncSel, sdaOeN}, 12'h001, "reset sync");
    for (int k = 0; k < 4; k++) begin
      @(negedge mclk);
      pins = 3'($urandom());
      own = {BASE_UPPER, pins};
      code = 10'($urandom());
      cmd = {5'($urandom()), 3'(k * 2)};
      repeat (10) @(negedge mclk);
      note(code, cmd);
      xfer({own, WRITE_BIT, cmd, code[7:0], 6'($urandom()), code[9:8]}, 4, 4'hF, "word");
    end
    cmd = 8'hFC;
    note(curOut[11:2], cmd);
    xfer({own, WRITE_BIT, cmd, 16'h0000}, 2, 4'h3, "send byte");
    cmd = 8'h02;
    note(curOut[11:2], cmd);
    xfer({own, WRITE_BIT, cmd, 8'h5A, 8'h00}, 3, 4'h7, "cut data");
    sdwd_host_inst.frame_start();
    sdwd_host_inst.send_bits({own, WRITE_BIT}, 8, a);
    sdwd_host_inst.send_bits(8'h5F, 4, a);
    sdwd_host_inst.frame_stop();
    repeat (20) @(negedge mclk);
    chk({11'h000, syncSel}, 12'h000, "cut command");
    $display("test cut command done");
    xfer({4'h5, pins, WRITE_BIT, 24'h060000}, 2, 4'h0, "foreign address");
    xfer({own, 1'b1, 24'h000000}, 1, 4'h0, "read bit");
    xfer({SYNC_ADDR, 1'b1, 24'h000000}, 1, 4'h1, "idle sync");
    code = 10'($urandom());
    cmd = 8'h05;
    xfer({own, WRITE_BIT, cmd, code[7:0], 6'h00, code[9:8]}, 4, 4'hF, "deferred");
    chk({11'h000, syncSel}, 12'h001, "sync bit");
    note(code, cmd);
    xfer({SYNC_ADDR, 1'b1, 24'h000000}, 1, 4'h1, "sync update");
    note(10'h000, 8'h00);
    xfer({SYNC_ADDR, 1'b0, 24'h000000}, 1, 4'h1, "clear");
    chk({11'h000, syncSel}, 12'h000, "clear sync");
    chk(12'(expQ.size()), 12'h000, "notes left");
    tally_and_finish();
  end
endmodule
`default_nettype wire
